//--- bsl_pkg.sv
// Package for the burst sequencing and latency block of the DDR pseudo-static memory.
// Assumes a single 200 MHz core clock; the link clock is sampled as ordinary data.
package bsl_pkg;

	// Link command/address phase layout (48 bits, six bytes)
	localparam int CA_BYTES     = 6;
	localparam int CA_BIT_RW    = 47;
	localparam int CA_BIT_SPACE = 46;
	localparam int CA_BIT_BURST = 45;
	localparam int CA_UP_HI     = 44;
	localparam int CA_UP_LO     = 16;
	localparam int CA_LO_HI     = 2;
	localparam int WADDR_W      = 32;

	// Primary configuration register layout and reset value
	typedef struct packed {
		logic       pd_run;
		logic [2:0] drive;
		logic [3:0] rsvd;
		logic [3:0] lat_code;
		logic       fixed_lat;
		logic       legacy_wrap;
		logic [1:0] blen;
	} bsl_cfg_t;

	localparam logic [15:0] CFG_RESET   = 16'h8f2f;
	localparam logic [3:0]  LAT_CODE_5  = 4'h0;
	localparam logic [3:0]  LAT_CODE_6  = 4'h1;
	localparam logic [3:0]  LAT_CODE_7  = 4'h2;
	localparam logic [3:0]  LAT_CODE_3  = 4'he;
	localparam logic [3:0]  LAT_CODE_4  = 4'hf;
	localparam logic [1:0]  BLEN_128    = 2'h0;
	localparam logic [1:0]  BLEN_64     = 2'h1;
	localparam logic [1:0]  BLEN_16     = 2'h2;
	localparam logic [1:0]  BLEN_32     = 2'h3;

	// Register-space word address of the primary configuration register on the link
	localparam logic [31:0] LINK_CFG_ADDR = 32'h0000_0800;

	// APB map
	localparam logic [7:0] APB_CFG  = 8'h00;
	localparam logic [7:0] APB_STAT = 8'h04;
	localparam logic [7:0] APB_ADDR = 8'h08;

	typedef enum logic [1:0] {
		BSL_LINEAR,
		BSL_WRAP,
		BSL_HYBRID
	} bsl_mode_t;

	typedef struct packed {
		logic       we;
		logic [1:0] be_n;
		logic [WADDR_W-1:0] addr;
		logic [15:0] wdata;
	} bsl_mem_req_t;

	// Latency clocks per code; zero marks a reserved code
	function automatic logic [3:0] lat_clocks(input logic [3:0] code);
		unique case (code)
			LAT_CODE_5: lat_clocks = 4'h5;
			LAT_CODE_6: lat_clocks = 4'h6;
			LAT_CODE_7: lat_clocks = 4'h7;
			LAT_CODE_3: lat_clocks = 4'h3;
			LAT_CODE_4: lat_clocks = 4'h4;
			default:    lat_clocks = 4'h0;
		endcase
	endfunction : lat_clocks

	// Wrap group size minus one, in 16-bit words
	function automatic logic [5:0] group_mask(input logic [1:0] blen);
		unique case (blen)
			BLEN_128: group_mask = 6'h3f;
			BLEN_64:  group_mask = 6'h1f;
			BLEN_16:  group_mask = 6'h07;
			BLEN_32:  group_mask = 6'h0f;
		endcase
	endfunction : group_mask

endpackage : bsl_pkg

//--- bsl_addr_seq.sv
// Word address sequencer: linear, wrapped and hybrid burst orders.
// Assumes load and step are single-cycle strobes from the link controller.
`timescale 1ns/10ps
module bsl_addr_seq #(
	parameter int AW = bsl_pkg::WADDR_W
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// Control
	input  wire logic              load,
	input  wire logic              step,
	input  wire logic [AW-1:0]     start_addr,
	input  wire bsl_pkg::bsl_mode_t mode,
	input  wire logic [1:0]        blen,
	// Current word address
	output logic      [AW-1:0]     addr
);

	logic [AW-1:0]      addr_ff;
	logic [AW-1:0]      nxt_addr;
	logic [AW-1:0]      mask;
	logic [AW-1:0]      base;
	logic [5:0]         count_ff;
	logic               wrapped_ff;
	bsl_pkg::bsl_mode_t mode_ff;

	assign mask = AW'(bsl_pkg::group_mask(blen));
	assign base = addr_ff & ~mask;
	assign addr = addr_ff;

	always_comb
	begin
		nxt_addr = addr_ff + AW'(1);
		if (mode_ff == bsl_pkg::BSL_WRAP)
			nxt_addr = base | ((addr_ff + AW'(1)) & mask);
		else if (mode_ff == bsl_pkg::BSL_HYBRID && !wrapped_ff)
		begin
			// Last word of the single wrap jumps past the group, not back to the start
			if (AW'(count_ff) == mask)
				nxt_addr = base + mask + AW'(1);
			else
				nxt_addr = base | ((addr_ff + AW'(1)) & mask);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			addr_ff    <= '0;
			count_ff   <= '0;
			wrapped_ff <= 1'b0;
			mode_ff    <= bsl_pkg::BSL_LINEAR;
		end
		else if (load)
		begin
			addr_ff    <= start_addr;
			count_ff   <= '0;
			wrapped_ff <= 1'b0;
			mode_ff    <= mode;
		end
		else if (step)
		begin
			addr_ff  <= nxt_addr;
			count_ff <= count_ff + 6'h01;
			if (AW'(count_ff) == mask)
				wrapped_ff <= 1'b1;
		end
	end

endmodule : bsl_addr_seq

//--- bsl_link_ctrl.sv
// Device end of the DDR memory link: command/address capture, initial latency,
// strobe signalling, burst data transfer and the configuration register.
// Assumes link pins are asynchronous to core_clk and the link clock is far slower.
`timescale 1ns/10ps

// Summary of operation
// - Hybrid 128-byte: wrap once through 64 words, then linear from next group.
// - Hybrid 64-byte from 2E: 2E..3F, 20..2D, then linear from 40.
// - Hybrid 16-byte from 0C: 0C..0F, 08..0B, then linear from 10.
// - Hybrid 32-byte: wrap once in 16 words, then next 16-word boundary.
// - Plain wrap: increment to group top, return to base, never leave.
// - Linear: increment word address by one per word until transfer ends.
// - Memory reads, writes and register reads wait an initial latency.
// - Latency clocks come from the configuration latency field, 3 to 7.
// - Latency resets to 7 clocks.
// - Pending refresh drives strobe high during command phase and doubles latency.
// - Register writes have zero latency; data follows the command phase.
// - Strobe level during a register write command is ignored.
// - Refresh may run while register write data is captured.
// - Fixed-latency bit set: strobe always high, two latency periods.
// - Fixed-latency mode after reset.
// - Latency codes 0,1,2,E,F give 5,6,7,3,4 clocks; others reserved.
// - Hybrid bit 0 selects hybrid, 1 plain wrap; only for wrapped bursts.
// - Burst length 00/01/10/11 gives 128/64/16/32-byte groups.
// - Fixed latency only; writing 0 there is reserved.
module bsl_link_ctrl (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Link pins
	input  wire logic                 link_clk,
	input  wire logic                 cs_n,
	input  wire logic [7:0]           dq_in,
	output logic      [7:0]           dq_out,
	output logic                      dq_oe,
	input  wire logic                 read_write_strobe_in,
	output logic                      read_write_strobe_out,
	output logic                      read_write_strobe_oe,
	// Array side
	input  wire logic                 refresh_pending,
	output logic                      mem_req,
	output bsl_pkg::bsl_mem_req_t     mem_cmd,
	input  wire logic [15:0]          mem_rdata,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CA,
		ST_LAT,
		ST_RDATA,
		ST_WDATA,
		ST_HOLD
	} bsl_state_t;

	logic [1:0]   clk_sync_ff;
	logic [1:0]   cs_sync_ff;
	logic [1:0]   read_write_strobe_sync_ff;
	logic [7:0]   dq_sync0_ff;
	logic [7:0]   dq_sync1_ff;
	logic         clk_prev_ff;
	logic         rise;
	logic         fall;
	logic         edge_seen;
	logic         cs_act;

	bsl_state_t   state_ff;
	logic [47:0]  ca_ff;
	logic [47:0]  nxt_ca;
	logic [2:0]   ca_cnt_ff;
	logic [4:0]   lat_cnt_ff;
	logic         dbl_ff;
	logic         byte_sel_ff;
	logic [7:0]   hi_byte_ff;
	logic         hi_mask_ff;
	bsl_pkg::bsl_cfg_t cfg_ff;
	bsl_pkg::bsl_cfg_t cfg;
	bsl_pkg::bsl_cfg_t cfg_new;
	logic         rd_next_ff;
	logic [15:0]  rd_word;
	logic         rd_req;
	logic         seq_load;
	logic         seq_step;
	logic [bsl_pkg::WADDR_W-1:0] seq_addr;
	logic [bsl_pkg::WADDR_W-1:0] start_addr;
	bsl_pkg::bsl_mode_t          mode;
	logic         ca_done;
	logic         is_read;
	logic         is_reg;
	logic         apb_wr;
	logic         link_cfg_wr;
	logic [15:0]  link_cfg_word;

	assign cfg       = cfg_ff;
	assign rise      = clk_sync_ff[1] & ~clk_prev_ff;
	assign fall      = ~clk_sync_ff[1] & clk_prev_ff;
	assign edge_seen = rise | fall;
	assign cs_act    = ~cs_sync_ff[1];
	assign nxt_ca    = {ca_ff[39:0], dq_sync1_ff};
	assign ca_done   = state_ff == ST_CA && edge_seen && ca_cnt_ff == 3'(bsl_pkg::CA_BYTES - 1);
	assign is_read   = nxt_ca[bsl_pkg::CA_BIT_RW];
	assign is_reg    = nxt_ca[bsl_pkg::CA_BIT_SPACE];
	assign start_addr = {nxt_ca[bsl_pkg::CA_UP_HI:bsl_pkg::CA_UP_LO], nxt_ca[bsl_pkg::CA_LO_HI:0]};

	// Burst type bit set means linear; the hybrid bit only matters for wrapped bursts
	always_comb
	begin
		if (nxt_ca[bsl_pkg::CA_BIT_BURST])
			mode = bsl_pkg::BSL_LINEAR;
		else if (cfg.legacy_wrap)
			mode = bsl_pkg::BSL_WRAP;
		else
			mode = bsl_pkg::BSL_HYBRID;
	end

	// Two flip-flops on every pin before any logic reads it
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			clk_sync_ff  <= '0;
			cs_sync_ff   <= 2'h3;
			read_write_strobe_sync_ff <= '0;
			dq_sync0_ff  <= '0;
			dq_sync1_ff  <= '0;
			clk_prev_ff  <= 1'b0;
		end
		else
		begin
			clk_sync_ff  <= {clk_sync_ff[0], link_clk};
			cs_sync_ff   <= {cs_sync_ff[0], cs_n};
			read_write_strobe_sync_ff <= {read_write_strobe_sync_ff[0], read_write_strobe_in};
			dq_sync0_ff  <= dq_in;
			dq_sync1_ff  <= dq_sync0_ff;
			clk_prev_ff  <= clk_sync_ff[1];
		end
	end

	// Transaction sequencing
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_ff    <= ST_IDLE;
			ca_ff       <= '0;
			ca_cnt_ff   <= '0;
			lat_cnt_ff  <= '0;
			dbl_ff      <= 1'b0;
			byte_sel_ff <= 1'b0;
		end
		else if (!cs_act)
			state_ff <= ST_IDLE;
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					state_ff  <= ST_CA;
					ca_cnt_ff <= '0;
					// Refresh need is decided once, as the transaction begins
					dbl_ff    <= cfg.fixed_lat | refresh_pending;
				end
				ST_CA:
				begin
					if (edge_seen)
					begin
						ca_ff     <= nxt_ca;
						ca_cnt_ff <= ca_cnt_ff + 3'h1;
					end
					byte_sel_ff <= 1'b0;
					if (ca_done)
					begin
						if (is_reg && !is_read)
							state_ff <= ST_WDATA;
						else
						begin
							state_ff   <= ST_LAT;
							lat_cnt_ff <= dbl_ff
								? {bsl_pkg::lat_clocks(cfg.lat_code), 1'b0}
								: {1'b0, bsl_pkg::lat_clocks(cfg.lat_code)};
						end
					end
				end
				ST_LAT:
				begin
					if (rise)
					begin
						lat_cnt_ff <= lat_cnt_ff - 5'h01;
						if (lat_cnt_ff == 5'h01)
							state_ff <= ca_ff[bsl_pkg::CA_BIT_RW] ? ST_RDATA : ST_WDATA;
					end
				end
				ST_RDATA, ST_WDATA:
				begin
					if (edge_seen)
						byte_sel_ff <= ~byte_sel_ff;
				end
				ST_HOLD:
					state_ff <= ST_HOLD;
			endcase
		end
	end

	assign seq_load = ca_done;
	assign seq_step = (state_ff == ST_RDATA || state_ff == ST_WDATA) && edge_seen && byte_sel_ff;
	// Fetch the first word as latency ends, then one per word transferred
	// Later words wait one cycle for the sequencer to step, so wrap orders hold
	assign rd_req   = (state_ff == ST_LAT && rise && lat_cnt_ff == 5'h01 && ca_ff[bsl_pkg::CA_BIT_RW]
		&& !ca_ff[bsl_pkg::CA_BIT_SPACE]) || (state_ff == ST_RDATA && rd_next_ff);

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rd_next_ff <= 1'b0;
		else
			rd_next_ff <= state_ff == ST_RDATA && seq_step && !ca_ff[bsl_pkg::CA_BIT_SPACE];
	end

	bsl_addr_seq #(
		.AW         (bsl_pkg::WADDR_W)
	) u_seq (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.load       (seq_load),
		.step       (seq_step),
		.start_addr (start_addr),
		.mode       (mode),
		.blen       (cfg.blen),
		.addr       (seq_addr)
	);

	// Register reads return the configuration word, otherwise array data
	assign rd_word = ca_ff[bsl_pkg::CA_BIT_SPACE] ? cfg_ff : mem_rdata;

	// Read data and strobe drive; strobe is a level in the command phase
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			dq_out   <= '0;
			dq_oe    <= 1'b0;
			read_write_strobe_out <= 1'b0;
			read_write_strobe_oe  <= 1'b0;
		end
		else
		begin
			read_write_strobe_oe <= cs_act && (state_ff == ST_CA || state_ff == ST_IDLE
				|| (state_ff == ST_LAT && ca_ff[bsl_pkg::CA_BIT_RW]) || state_ff == ST_RDATA);
			dq_oe   <= cs_act && state_ff == ST_RDATA;
			if (state_ff == ST_IDLE)
				read_write_strobe_out <= cfg.fixed_lat | refresh_pending;
			else if (state_ff == ST_LAT)
				read_write_strobe_out <= 1'b0;
			else if (state_ff == ST_RDATA && edge_seen)
			begin
				read_write_strobe_out <= ~byte_sel_ff;
				dq_out   <= byte_sel_ff ? rd_word[7:0] : rd_word[15:8];
			end
		end
	end

	// Write data pairing into words; strobe acts as byte mask for array writes
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			hi_byte_ff <= '0;
			hi_mask_ff <= 1'b0;
			mem_req    <= 1'b0;
			mem_cmd    <= '0;
		end
		else
		begin
			mem_req <= 1'b0;
			if (rd_req)
			begin
				mem_req      <= 1'b1;
				mem_cmd.we   <= 1'b0;
				mem_cmd.be_n <= '0;
				mem_cmd.addr <= seq_addr;
			end
			else if (state_ff == ST_WDATA && edge_seen && !byte_sel_ff)
			begin
				hi_byte_ff <= dq_sync1_ff;
				hi_mask_ff <= read_write_strobe_sync_ff[1];
			end
			else if (state_ff == ST_WDATA && seq_step && !ca_ff[bsl_pkg::CA_BIT_SPACE])
			begin
				mem_req       <= 1'b1;
				mem_cmd.we    <= 1'b1;
				mem_cmd.be_n  <= {hi_mask_ff, read_write_strobe_sync_ff[1]};
				mem_cmd.addr  <= seq_addr;
				mem_cmd.wdata <= {hi_byte_ff, dq_sync1_ff};
			end
		end
	end

	// Register write from the link ignores the strobe and any refresh in progress
	assign link_cfg_wr   = state_ff == ST_WDATA && seq_step && ca_ff[bsl_pkg::CA_BIT_SPACE]
		&& seq_addr == bsl_pkg::LINK_CFG_ADDR;
	assign link_cfg_word = {hi_byte_ff, dq_sync1_ff};
	assign apb_wr        = psel && penable && pwrite && paddr == bsl_pkg::APB_CFG;
	assign cfg_new       = bsl_pkg::bsl_cfg_t'(link_cfg_wr ? link_cfg_word : pwdata[15:0]);

	// Configuration register; reserved latency codes leave the field unchanged
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cfg_ff <= bsl_pkg::bsl_cfg_t'(bsl_pkg::CFG_RESET);
		else if (link_cfg_wr || apb_wr)
		begin
			cfg_ff <= cfg_new;
			if (bsl_pkg::lat_clocks(cfg_new.lat_code) == 4'h0)
				cfg_ff.lat_code <= cfg_ff.lat_code;
			cfg_ff.fixed_lat <= 1'b1;
		end
	end

	// APB slave: zero wait states, error on unmapped offsets
	assign pready  = 1'b1;
	assign pslverr = psel && penable && paddr != bsl_pkg::APB_CFG
		&& paddr != bsl_pkg::APB_STAT && paddr != bsl_pkg::APB_ADDR;

	always_comb
	begin
		prdata = '0;
		if (psel && !pwrite)
		begin
			unique case (paddr)
				bsl_pkg::APB_CFG:  prdata = {16'h0000, cfg_ff};
				bsl_pkg::APB_STAT: prdata = {26'h0, dbl_ff, cs_act, state_ff, byte_sel_ff};
				bsl_pkg::APB_ADDR: prdata = seq_addr;
				default:           prdata = '0;
			endcase
		end
	end

endmodule : bsl_link_ctrl

//--- bsl_link_ctrl_props.sv
// Port checker for the link controller.
// Bound to bsl_link_ctrl; it sees that module's ports and nothing else.
`timescale 1ns/10ps
module bsl_link_ctrl_props (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Link and array
	input  wire logic        cs_n,
	input  wire logic        dq_oe,
	input  wire logic        read_write_strobe_oe,
	input  wire logic        read_write_strobe_out,
	input  wire logic        mem_req,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic acc;
	logic hit;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	assign acc = psel && penable;
	assign hit = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;

	reset_quiet_a: assert property ($rose(rst_n) |-> !dq_oe && !read_write_strobe_oe && !mem_req)
		else $error("outputs active after reset");
	apb_ready_a: assert property (acc |-> pready)
		else $error("apb access not ready");
	apb_unmapped_a: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	apb_mapped_a: assert property (acc && hit |-> !pslverr)
		else $error("mapped access refused");
	fixed_bit_a: assert property (acc && !pwrite && paddr == 8'h00 |-> prdata[3])
		else $error("fixed latency bit clear");
	ca_strobe_a: assert property ($fell(cs_n) ##[1:5] $rose(read_write_strobe_oe) |-> read_write_strobe_out)
		else $error("strobe low in command phase");
	release_a: assert property ($rose(cs_n) |-> ##[1:6] !dq_oe && !read_write_strobe_oe)
		else $error("link not released");
	idle_a: assert property (cs_n [*6] |-> !dq_oe && !read_write_strobe_oe)
		else $error("link driven while idle");
	read_strobe_a: assert property (dq_oe |-> read_write_strobe_oe)
		else $error("data without strobe");
endmodule : bsl_link_ctrl_props

bind bsl_link_ctrl bsl_link_ctrl_props u_bsl_link_ctrl_props (.core_clk, .rst_n, .cs_n,
	.dq_oe, .read_write_strobe_oe, .read_write_strobe_out, .mem_req, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr);

//--- bsl_host_model.sv
// Host controller model: drives link clock, select, command bytes and write data.
// Assumes core_clk paces it; one link edge per 8 core cycles, an 80 ns period.
`timescale 1ns/10ps
module bsl_host_model (
	// Pacing clock
	input  wire logic       core_clk,
	// Link
	output logic            link_clk,
	output logic            cs_n,
	output logic [7:0]      dq_in,
	output logic            read_write_strobe_in,
	input  wire logic [7:0] dq_out,
	input  wire logic       dq_oe,
	input  wire logic       read_write_strobe_out,
	input  wire logic       read_write_strobe_oe
);
	logic [15:0] rd_q[$];
	logic        ca_strobe;
	int          first_edge;

	initial
	begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		dq_in = 8'h00;
		read_write_strobe_in = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	// Lat 0 is a register write; write data wd sends its upper word first
	task automatic xfer(input logic [47:0] ca, input int lat, input int nw,
		input logic [31:0] wd, input logic strobe);
		int         e;
		int         k;
		int         nb;
		int         start;
		logic [7:0] hi;
		logic       lr;
		rd_q.delete();
		first_edge = 0;
		nb = 0;
		start = 1;
		lr = 1'b0;
		cs_n <= 1'b0;
		read_write_strobe_in <= strobe;
		tick(4);
		// Clock only runs inside the frame and always ends low
		for (e = -5; e < start + 2 * nw || link_clk; e++)
		begin
			k = e - start;
			if (e <= 0)
				dq_in <= ca[47 - 8 * (e + 5) -: 8];
			else if (!ca[47] && k >= 0 && k < 4)
				dq_in <= wd[31 - 8 * k -: 8];
			else
				dq_in <= ~dq_in;
			tick(1);
			link_clk <= ~link_clk;
			tick(7);
			if (e == -3)
				ca_strobe = read_write_strobe_oe & read_write_strobe_out;
			if (e == 0)
			begin
				read_write_strobe_in <= 1'b0;
				start = (lat == 0) ? 1 : (ca_strobe ? 4 : 2) * lat;
			end
			// A new byte shows as a strobe toggle; dq_oe rises before the first byte
			if (e > 0 && dq_oe === 1'b1 && read_write_strobe_oe === 1'b1 && read_write_strobe_out !== lr)
			begin
				lr = read_write_strobe_out;
				if (first_edge == 0)
					first_edge = e;
				if (nb % 2 == 1)
					rd_q.push_back({hi, dq_out});
				else
					hi = dq_out;
				nb++;
			end
		end
		cs_n <= 1'b1;
		tick(6);
	endtask : xfer
endmodule : bsl_host_model

//--- bsl_link_ctrl_test.sv
// Testbench for the link controller: APB accesses and host link transfers.
// Assumes the host model paces the link; this bench plays the memory array.
`timescale 1ns/10ps
module bsl_link_ctrl_test;
	logic                  core_clk;
	logic                  rst_n, link_clk, cs_n, read_write_strobe_in, dq_oe, read_write_strobe_out, read_write_strobe_oe, err;
	logic                  refresh_pending, mem_req, psel, penable, pwrite, pready, pslverr;
	logic [7:0]            dq_in, dq_out, paddr;
	logic [15:0]           mem_rdata;
	logic [31:0]           pwdata, prdata, rd;
	bsl_pkg::bsl_mem_req_t mem_cmd;
	bsl_pkg::bsl_mem_req_t wq[$];
	int                    n_fail, tests_run, cyc;
	logic [3:0]            codes[5] = '{4'he, 4'hf, 4'h0, 4'h1, 4'h2};

	bsl_link_ctrl u_bsl_link_ctrl (.core_clk, .rst_n, .link_clk, .cs_n, .dq_in, .dq_out,
		.dq_oe, .read_write_strobe_in, .read_write_strobe_out, .read_write_strobe_oe, .refresh_pending, .mem_req, .mem_cmd,
		.mem_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	bsl_host_model u_bsl_host_model (.core_clk, .link_clk, .cs_n, .dq_in, .read_write_strobe_in,
		.dq_out, .dq_oe, .read_write_strobe_out, .read_write_strobe_oe);

	always #2.5 core_clk = ~core_clk;

	// Array stand-in: read data is the inverted word address
	always @(posedge core_clk)
	begin
		if (mem_req === 1'b1)
		begin
			mem_rdata <= ~mem_cmd.addr[15:0];
			if (mem_cmd.we === 1'b1)
				wq.push_back(mem_cmd);
		end
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_fail++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	function automatic logic [31:0] exp_addr(input int m, input logic [1:0] bl,
		input logic [31:0] s, input int i);
		logic [31:0] g;
		g = (bl == 2'h0) ? 64 : (bl == 2'h1) ? 32 : (bl == 2'h2) ? 8 : 16;
		if (m == 0)
			return s + i;
		if (m == 2 && i >= g)
			return (s & ~(g - 1)) + i;
		return (s & ~(g - 1)) + ((s + i) & (g - 1));
	endfunction : exp_addr

	// Mode 0 linear, 1 plain wrap, 2 hybrid
	task automatic burst(input int m, input logic [1:0] bl, input logic [31:0] s,
		input int nw, input logic [3:0] code, input int lat);
		apb(1'b1, 8'h00, {16'h0, 8'h8f, code, 1'b1, m == 1, bl});
		u_bsl_host_model.xfer({2'b10, m == 0, s[31:3], 13'h0, s[2:0]}, lat, nw, 0, 0);
		chk(u_bsl_host_model.ca_strobe, 1'b1);
		chk(u_bsl_host_model.first_edge, 4 * lat);
		for (int i = 0; i < nw; i++)
			chk(u_bsl_host_model.rd_q[i], exp_addr(m, bl, s, i) ^ 32'hffff);
		$display("test burst %0d at %h done", m, s);
	endtask : burst

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		{refresh_pending, psel, penable, pwrite, paddr, pwdata, mem_rdata} = '0;
		{n_fail, tests_run, cyc} = '0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_8f2f);
		apb(1'b0, 8'h0c, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
		for (int k = 0; k < 5; k++)
			burst(0, 2'h3, 32'h3, 3, codes[k], k + 3);
		apb(1'b1, 8'h00, 32'h8f33);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_8f2b);
		burst(2, 2'h0, 32'h03, 66, 4'he, 3);
		burst(2, 2'h1, 32'h2e, 34, 4'he, 3);
		burst(2, 2'h2, 32'h0c, 10, 4'he, 3);
		burst(2, 2'h3, 32'h0a, 18, 4'he, 3);
		burst(1, 2'h1, 32'h2e, 40, 4'he, 3);
		burst(1, 2'h2, 32'h0c, 10, 4'he, 3);
		refresh_pending <= 1'b1;
		u_bsl_host_model.xfer({3'b010, 29'h100, 16'h0}, 0, 1, 32'h8f1e_0000, 1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_8f1e);
		u_bsl_host_model.xfer({3'b110, 29'h100, 16'h0}, 6, 1, 0, 0);
		chk(u_bsl_host_model.rd_q[0], 32'h8f1e);
		chk(u_bsl_host_model.first_edge, 24);
		refresh_pending <= 1'b0;
		wq.delete();
		u_bsl_host_model.xfer({3'b001, 29'h2, 16'h0}, 6, 2, 32'h1234_abcd, 0);
		chk({wq[0].addr[15:0], wq[0].wdata}, 32'h0010_1234);
		chk({wq[1].addr[15:0], wq[1].wdata}, 32'h0011_abcd);
		$display("test register and write done");
		finish_test();
	end
endmodule : bsl_link_ctrl_test
